// [tb/rsc_board_model.sv]
// board side of the reset pins: pull-ups, por generator, external pulls
// assumes the testbench requests por and external lows on mclk
`timescale 1ns/100ps
module rsc_board_model (
  // clock
  input  wire logic mclk,
  // requests from the bench
  input  wire logic por_req,
  input  wire logic ext_hard_low,
  input  wire logic ext_soft_low,
  // device pin drivers
  input  wire logic hard_o,
  input  wire logic hard_oe_n,
  input  wire logic soft_o,
  input  wire logic soft_oe_n,
  // resolved wires
  output logic      por_n_pin,
  output logic      hard_pin,
  output logic      soft_pin
);
  logic [5:0] cnt_q;

  // por stays low 40 clocks after the request drops, clock already runs
  // test reset is not wired here, so por release answers to nothing else
  always_ff @(posedge mclk) begin
    if (por_req) cnt_q <= 6'h00;
    else if (cnt_q != 6'h28) cnt_q <= cnt_q + 6'h01;
  end
  assign por_n_pin = !por_req && (cnt_q == 6'h28);

  // open drain with pull-up: any party pulling low wins
  assign hard_pin = !((!hard_oe_n && !hard_o) || ext_hard_low);
  assign soft_pin = !((!soft_oe_n && !soft_o) || ext_soft_low);
endmodule // rsc_board_model

// [tb/rsc_ctrl_tb.sv]
// self-checking bench for rsc_ctrl with a board model on the reset pins
// assumes 250 MHz mclk; flows are measured by a queue-fed monitor
`timescale 1ns/100ps
module rsc_ctrl_tb;
  import rsc_pkg::*;
  typedef struct {logic [7:0] st; logic [6:0] hl; logic [6:0] sl;
                  logic ev;} rsc_exp_t;
  logic        mclk = 0, reset = 1, por_req = 1, eh = 0, es = 0;
  logic        por_n, hpin, spin, ho, hoe, so, soe;
  logic        jtag = 0, wen = 0, wz = 0, slk = 0, swh = 0, sws = 0;
  logic        core_reset, pll_reset, wev, valid;
  logic [2:0]  src_pin = 3'h0, csrc;
  logic [16:0] bus_pin = 17'h00000, cword, cfg_exp;
  logic [7:0]  status, st_s;
  logic [6:0]  hl, sl;
  logic        act = 0, ev, mon_on = 0;
  int          fails = 0, checks = 0, n;
  rsc_exp_t    q[$];
  rsc_exp_t    e;

  always #2 mclk = ~mclk;

  rsc_board_model BRD (.mclk(mclk), .por_req(por_req), .ext_hard_low(eh),
    .ext_soft_low(es), .hard_o(ho), .hard_oe_n(hoe), .soft_o(so),
    .soft_oe_n(soe), .por_n_pin(por_n), .hard_pin(hpin), .soft_pin(spin));

  rsc_ctrl DUT (.mclk(mclk), .reset(reset), .clk_en(1'b1),
    .power_on_reset_n(por_n), .hard_reset_n_i(hpin), .hard_reset_n_o(ho),
    .hard_reset_n_oe_n(hoe), .soft_reset_n_i(spin), .soft_reset_n_o(so),
    .soft_reset_n_oe_n(soe), .config_source_select(src_pin),
    .reset_config_bus(bus_pin), .jtag_host_reset(jtag), .wdog_enable(wen),
    .wdog_zero(wz), .slink_hard_req(slk), .sw_hard_req(swh),
    .sw_soft_req(sws), .core_reset(core_reset), .pll_reset(pll_reset),
    .wdog_reset_event(wev), .reset_status(status), .config_source(csrc),
    .reset_config_word(cword), .config_valid(valid));

  task automatic chk(string nm, logic [16:0] got, logic [16:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // bounded wait for core_reset to reach a level; running out fails
  task automatic wait_core(logic lvl, int lim);
    int k;
    k = 0;
    while (core_reset !== lvl && k < lim) begin
      @(negedge mclk);
      k++;
    end
    if (k >= lim) begin
      fails++;
      end_sim();
    end
  endtask

  // monitor: one episode per core_reset pulse, compared to the oldest note
  always @(posedge mclk) begin
    #1;
    if (mon_on && core_reset === 1'b1) begin
      if (!act) begin
        act = 1; st_s = status; hl = 0; sl = 0; ev = 0;
      end
      if (hoe === 1'b0) hl++;
      if (soe === 1'b0) sl++;
      if (wev === 1'b1) ev = 1;
    end else if (mon_on && act) begin
      act = 0;
      if (q.size() == 0) chk("note", 17'h1, 17'h0);
      else begin
        e = q.pop_front();
        chk("status", 17'(st_s), 17'(e.st));
        chk("hard_len", 17'(hl), 17'(e.hl));
        chk("soft_len", 17'(sl), 17'(e.sl));
        chk("wdog_ev", 17'(ev), 17'(e.ev));
        chk("cfg_word", cword, cfg_exp);
        chk("cfg_src", 17'(csrc), 17'h5);
        chk("pll", 17'(pll_reset), 17'h0);
      end
    end
  end

  // one request vector {sw_soft,sw_hard,slink,wdog,jtag,ext_soft,ext_hard}
  task automatic flow(logic [6:0] r, logic [7:0] st, logic hard, bit late);
    q.push_back('{st, hard ? 7'd32 : 7'd0, hard ? 7'd48 : 7'd16, r[3]});
    @(negedge mclk);
    {sws, swh, slk, wen, jtag, es, eh} = r;
    wz = r[3];
    src_pin = 3'($urandom); // config pins wander, word must not
    bus_pin = 17'($urandom);
    @(negedge mclk);
    {sws, swh, slk, wen, jtag, es, eh, wz} = 8'h00;
    // pin requests cross the syncs, so such a flow starts a few edges late
    wait_core(1'b1, 8);
    if (late) begin
      repeat (8) @(negedge mclk);
      es = 1; // ignored while device drives reset
      @(negedge mclk);
      es = 0;
    end
    wait_core(1'b0, 100);
    repeat (8) @(negedge mclk);
  endtask

  initial begin
    void'($urandom(53));
    repeat (8) @(negedge mclk);
    reset = 0;
    repeat (20) @(negedge mclk);
    cfg_exp = 17'($urandom);
    bus_pin = cfg_exp;
    src_pin = 3'h5;
    @(negedge mclk);
    chk("por_pll", 17'(pll_reset), 17'h1);
    chk("por_st", 17'(status), 17'h01);
    chk("por_pins", 17'({hoe, soe}), 17'h0);
    por_req = 0;
    n = 0;
    while (hoe !== 1'b1 && n < 120) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 120) begin
      fails++;
      end_sim();
    end
    chk("cfg_src", 17'(csrc), 17'h5);
    chk("cfg_word", cword, cfg_exp);
    chk("valid", 17'(valid), 17'h1);
    n = 0;
    while (soe !== 1'b1 && n < 40) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 40) begin
      fails++;
      end_sim();
    end
    chk("soft_tail", 17'(n), 17'h10);
    repeat (8) @(negedge mclk);
    mon_on = 1;
    flow(7'b0100000, 8'h40, 1, 1);
    flow(7'b0000100, 8'h08, 0, 0);
    flow(7'b1000000, 8'h80, 0, 0);
    flow(7'b0001000, 8'h10, 1, 0);
    flow(7'b0010000, 8'h20, 1, 0);
    flow(7'b0000001, 8'h02, 1, 0);
    flow(7'b0000010, 8'h04, 0, 0);
    flow(7'b1100000, 8'h40, 1, 0);
    // count at zero without enable does nothing
    @(negedge mclk);
    wz = 1;
    repeat (10) @(negedge mclk);
    chk("wdog_off", 17'(core_reset), 17'h0);
    wz = 0;
    repeat (4) @(negedge mclk);
    chk("queue", 17'(q.size()), 17'h0);
    end_sim();
  end
endmodule // rsc_ctrl_tb

// [verilog/rsc_ctrl.sv]
// reset source controller: arbitrates reset requests, runs por/hard/soft
// assumes the board pulls both reset pins up and resolves the enables;
// software and internal requests arrive as mclk-synchronous levels
`timescale 1ns/100ps
module rsc_ctrl
  import rsc_pkg::*;
(
  // clock and control
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  // power-on reset pin
  input  wire logic        power_on_reset_n,
  // open-drain hard reset pin
  input  wire logic        hard_reset_n_i,
  output logic             hard_reset_n_o,
  output logic             hard_reset_n_oe_n,
  // open-drain soft reset pin
  input  wire logic        soft_reset_n_i,
  output logic             soft_reset_n_o,
  output logic             soft_reset_n_oe_n,
  // configuration pins
  input  wire logic [2:0]  config_source_select,
  input  wire logic [16:0] reset_config_bus,
  // internal requests
  input  wire logic        jtag_host_reset,
  input  wire logic        wdog_enable,
  input  wire logic        wdog_zero,
  input  wire logic        slink_hard_req,
  input  wire logic        sw_hard_req,
  input  wire logic        sw_soft_req,
  // reset outputs and captured state
  output logic             core_reset,
  output logic             pll_reset,
  output logic             wdog_reset_event,
  output logic [7:0]       reset_status,
  output logic [2:0]       config_source,
  output logic [16:0]      reset_config_word,
  output logic             config_valid
);
  typedef struct packed {
    rsc_state_t  st;
    logic [5:0]  cnt;
    logic [2:0]  blank;
    logic        hard_oe_n;
    logic        soft_oe_n;
    logic        pin_lvl;
    logic        core_rst;
    logic        pll_rst;
    logic        wdog_evt;
    logic [7:0]  status;
    logic [2:0]  cfg_src;
    logic [16:0] cfg_word;
    logic        cfg_valid;
  } rsc_ctrl_t;

  rsc_ctrl_t  q, d;
  rsc_pins_if pins ();
  logic [7:0] hard_v;
  logic [7:0] soft_v;
  logic       hard_ok;
  logic       drive_none;

  rsc_sync u_sync (
    .mclk        (mclk),
    .reset       (reset),
    .clk_en      (clk_en),
    .por_n_pin   (power_on_reset_n),
    .hard_n_pin  (hard_reset_n_i),
    .soft_n_pin  (soft_reset_n_i),
    .cfg_src_pin (config_source_select),
    .cfg_bus_pin (reset_config_bus),
    .pins        (pins)
  );

  // our own drive reads back low, so pins count only outside that window
  always_comb begin
    drive_none = q.hard_oe_n && q.soft_oe_n && (q.blank == 3'h0);
    hard_ok    = ((q.st == ST_IDLE) && (q.blank == 3'h0)) ||
                 (q.st == ST_SOFT) ||
                 ((q.st == ST_TAIL) &&
                  (q.cnt < 6'(SOFT_TAIL_CYC - 6'(PIN_BLANK_CYC))));
    hard_v               = 8'h00;
    hard_v[SRC_HARD_PIN] = hard_ok && !pins.hard_n;
    hard_v[SRC_WDOG]     = wdog_enable && wdog_zero;
    hard_v[SRC_SLINK]    = slink_hard_req;
    hard_v[SRC_SW_HARD]  = sw_hard_req;
    soft_v               = 8'h00;
    soft_v[SRC_SOFT_PIN] = (q.st == ST_IDLE) && drive_none &&
                           !pins.soft_n;
    soft_v[SRC_JTAG]     = jtag_host_reset;
    soft_v[SRC_SW_SOFT]  = sw_soft_req;
  end

  // sequencer; por overrides everything, hard beats soft
  always_comb begin
    d          = q;
    d.wdog_evt = 1'b0;
    case (q.st)
      ST_POR: begin
        if (pins.por_n) begin
          d.st        = ST_HARD;
          d.cnt       = HARD_HOLD_CYC - 6'h01;
          d.cfg_valid = 1'b1;
        end
      end
      ST_IDLE: begin
        if (q.blank != 3'h0) begin
          d.blank = q.blank - 3'h1;
        end
        if (|hard_v) begin
          d.st       = ST_HARD;
          d.cnt      = HARD_HOLD_CYC - 6'h01;
          d.status   = hard_v;
          d.wdog_evt = hard_v[SRC_WDOG];
        end else if (|soft_v) begin
          d.st     = ST_SOFT;
          d.cnt    = SOFT_HOLD_CYC - 6'h01;
          d.status = soft_v;
        end
      end
      ST_HARD: begin
        if (q.cnt == 6'h00) begin
          d.st  = ST_TAIL;
          d.cnt = SOFT_TAIL_CYC - 6'h01;
        end else begin
          d.cnt = q.cnt - 6'h01;
        end
      end
      ST_TAIL, ST_SOFT: begin
        if (|hard_v) begin
          d.st       = ST_HARD;
          d.cnt      = HARD_HOLD_CYC - 6'h01;
          d.status   = hard_v;
          d.wdog_evt = hard_v[SRC_WDOG];
        end else if (q.cnt == 6'h00) begin
          d.st    = ST_IDLE;
          d.blank = PIN_BLANK_CYC;
        end else begin
          d.cnt = q.cnt - 6'h01;
        end
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase
    // config is sampled only while por is held, never by hard flows
    if (!pins.por_n) begin
      d.st       = ST_POR;
      d.wdog_evt = 1'b0;
      d.cfg_src  = pins.cfg_src;
      d.cfg_word = pins.cfg_bus;
      // status names por while held, also right after a bench reset
      d.status          = STATUS_RST;
      d.status[SRC_POR] = 1'b1;
    end
    // outputs follow the next state so they leave flip-flops
    d.hard_oe_n = !((d.st == ST_POR) || (d.st == ST_HARD));
    d.soft_oe_n = (d.st == ST_IDLE);
    d.core_rst  = (d.st != ST_IDLE);
    d.pll_rst   = (d.st == ST_POR);
    d.pin_lvl   = 1'b0;
  end

  // reset lands in the por flow so a full sequence always follows
  always_ff @(posedge mclk) begin
    if (reset) begin
      q <= '{st: ST_POR, cnt: 6'h00, blank: 3'h0, hard_oe_n: 1'b0,
             soft_oe_n: 1'b0, pin_lvl: 1'b0, core_rst: 1'b1,
             pll_rst: 1'b1, wdog_evt: 1'b0, status: STATUS_RST,
             cfg_src: CFG_SRC_RST, cfg_word: CFG_WORD_RST,
             cfg_valid: 1'b0};
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign hard_reset_n_o    = q.pin_lvl;
  assign hard_reset_n_oe_n = q.hard_oe_n;
  assign soft_reset_n_o    = q.pin_lvl;
  assign soft_reset_n_oe_n = q.soft_oe_n;
  assign core_reset        = q.core_rst;
  assign pll_reset         = q.pll_rst;
  assign wdog_reset_event  = q.wdog_evt;
  assign reset_status      = q.status;
  assign config_source     = q.cfg_src;
  assign reset_config_word = q.cfg_word;
  assign config_valid      = q.cfg_valid;

  // checks; frozen cycles are excluded
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset || !clk_en);

  property p_por_drive;
    !pins.por_n |=> !q.hard_oe_n && !q.soft_oe_n && q.pll_rst && q.core_rst;
  endproperty
  a_por_drive: assert property (p_por_drive)
    else $error("por does not drive both pins and resets");

  property p_cfg_por_only;
    $changed(q.cfg_word) || $changed(q.cfg_src) |-> $past(!pins.por_n);
  endproperty
  a_cfg_por_only: assert property (p_cfg_por_only)
    else $error("config captured outside power-on reset");

  property p_hard_soft;
    !q.hard_oe_n |-> !q.soft_oe_n;
  endproperty
  a_hard_soft: assert property (p_hard_soft)
    else $error("hard reset driven without soft reset");

  property p_pin_hard;
    q.st == ST_IDLE && q.blank == 3'h0 && pins.por_n && !pins.hard_n
      |=> !q.hard_oe_n && q.status[SRC_HARD_PIN] ##1 !q.hard_oe_n;
  endproperty
  a_pin_hard: assert property (p_pin_hard)
    else $error("external hard low did not start hard flow");

  property p_soft_pin_idle;
    $rose(q.status[SRC_SOFT_PIN]) |-> $past(q.hard_oe_n && q.soft_oe_n);
  endproperty
  a_soft_pin_idle: assert property (p_soft_pin_idle)
    else $error("soft pin accepted while device drove reset");

  property p_soft_flow;
    q.st == ST_SOFT |-> q.hard_oe_n && !q.soft_oe_n && q.core_rst &&
                        !q.pll_rst && $stable(q.cfg_word);
  endproperty
  a_soft_flow: assert property (p_soft_flow)
    else $error("soft flow outputs wrong");

  property p_jtag;
    q.st == ST_IDLE && pins.por_n && jtag_host_reset && !(|hard_v)
      |=> q.st == ST_SOFT && q.status[SRC_JTAG] && !q.soft_oe_n;
  endproperty
  a_jtag: assert property (p_jtag)
    else $error("jtag command did not start soft flow");

  property p_wdog;
    q.st == ST_IDLE && pins.por_n && wdog_enable && wdog_zero
      |=> q.wdog_evt && !q.hard_oe_n ##1 !q.wdog_evt;
  endproperty
  a_wdog: assert property (p_wdog)
    else $error("watchdog expiry did not start hard flow");

  property p_slink;
    q.st == ST_IDLE && pins.por_n && slink_hard_req
      |=> q.st == ST_HARD && q.status[SRC_SLINK];
  endproperty
  a_slink: assert property (p_slink)
    else $error("serial link request lost");

  property p_hard_wins;
    q.st == ST_IDLE && pins.por_n && sw_hard_req && sw_soft_req
      |=> q.st == ST_HARD && !q.status[SRC_SW_SOFT];
  endproperty
  a_hard_wins: assert property (p_hard_wins)
    else $error("soft flow taken over pending hard request");

  property p_tail;
    q.st == ST_HARD && q.cnt == 6'h00 && pins.por_n && !(|hard_v)
      |=> q.hard_oe_n && !q.soft_oe_n ##15 !q.soft_oe_n ##1
          (q.soft_oe_n || q.st != ST_IDLE);
  endproperty
  a_tail: assert property (p_tail)
    else $error("soft release not 16 cycles after hard release");

  c_por_flow: cover property ($rose(q.cfg_valid));
  c_soft_pin: cover property ($rose(q.status[SRC_SOFT_PIN]));
  c_tail_done: cover property (q.st == ST_TAIL ##1 q.st == ST_IDLE);
  c_wdog: cover property (q.wdog_evt);
endmodule // rsc_ctrl

// [verilog/rsc_pins_if.sv]
// synchronised pin levels passed from the input syncs to the sequencer
// assumes both ends run on mclk
`timescale 1ns/100ps
interface rsc_pins_if;
  logic        por_n;
  logic        hard_n;
  logic        soft_n;
  logic [2:0]  cfg_src;
  logic [16:0] cfg_bus;
  modport sync (output por_n, hard_n, soft_n, cfg_src, cfg_bus);
  modport core (input por_n, hard_n, soft_n, cfg_src, cfg_bus);
endinterface

// [verilog/rsc_pkg.sv]
// reset source controller: shared constants, source bit map, states
// assumes mclk is the reference clock, so reference cycles equal mclk cycles
package rsc_pkg;
  // hard hold after a request or power-on release, soft-only flow length
  localparam logic [5:0]  HARD_HOLD_CYC = 6'h20;
  localparam logic [5:0]  SOFT_HOLD_CYC = 6'h10;
  // soft release trails hard release, in reference clock cycles
  localparam int          SOFT_TAIL_REF = 16;
  localparam int          REF_PER_MCLK  = 1;
  localparam logic [5:0]  SOFT_TAIL_CYC = 6'(SOFT_TAIL_REF * REF_PER_MCLK);
  // pins are ignored while our own release ripples through the syncs
  localparam logic [2:0]  PIN_BLANK_CYC = 3'h4;
  // status bit positions, one per reset source
  localparam int          SRC_POR       = 0;
  localparam int          SRC_HARD_PIN  = 1;
  localparam int          SRC_SOFT_PIN  = 2;
  localparam int          SRC_JTAG      = 3;
  localparam int          SRC_WDOG      = 4;
  localparam int          SRC_SLINK     = 5;
  localparam int          SRC_SW_HARD   = 6;
  localparam int          SRC_SW_SOFT   = 7;
  // values after reset
  localparam logic [7:0]  STATUS_RST    = 8'h00;
  localparam logic [2:0]  CFG_SRC_RST   = 3'h0;
  localparam logic [16:0] CFG_WORD_RST  = 17'h00000;
  // sync chain {cfg bus, cfg source, soft, hard, por}: por low, pins high
  localparam logic [22:0] SYNC_RST      = 23'h000006;

  typedef enum logic [2:0] {
    ST_IDLE, ST_POR, ST_HARD, ST_TAIL, ST_SOFT
  } rsc_state_t;
endpackage

// [verilog/rsc_sync.sv]
// two-flop synchronisers for every pin that reaches the sequencer
// assumes pins are asynchronous to mclk; config pins are static during por
`timescale 1ns/100ps
module rsc_sync
  import rsc_pkg::*;
(
  // clock and control
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  // raw pin levels
  input  wire logic        por_n_pin,
  input  wire logic        hard_n_pin,
  input  wire logic        soft_n_pin,
  input  wire logic [2:0]  cfg_src_pin,
  input  wire logic [16:0] cfg_bus_pin,
  // synchronised levels
  rsc_pins_if.sync         pins
);
  typedef struct packed {
    logic [22:0] s1;
    logic [22:0] s2;
  } rsc_sync_t;

  rsc_sync_t q, d;

  // stage one feeds stage two only
  always_comb begin
    d    = q;
    d.s1 = {cfg_bus_pin, cfg_src_pin, soft_n_pin, hard_n_pin, por_n_pin};
    d.s2 = q.s1;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      q <= '{s1: SYNC_RST, s2: SYNC_RST};
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign pins.por_n   = q.s2[0];
  assign pins.hard_n  = q.s2[1];
  assign pins.soft_n  = q.s2[2];
  assign pins.cfg_src = q.s2[5:3];
  assign pins.cfg_bus = q.s2[22:6];
endmodule // rsc_sync
